/* logic/mte_entry_regs.sv */
`timescale 1ns/1ns
`include "mte_params.svh"

// Overview of operation
// RULE1: Bit 18 clear: single port, 011 reserved.
// RULE2: Bit 18 set: two or three ports selected.
// RULE3: Staged low half holds last 16 MAC bits.
// RULE4: Lower read-back word gives first 32 MAC bits.
// RULE5: Read-back words load only from walk commands.
// RULE6: Software trusts read-back only when valid/end set.
// RULE7: Valid clears on walk command, sets when found.
// RULE8: End-of-table flag set when walk reaches end.
// RULE9: Static flag reports entry exempt from aging.
// RULE10: Filter flag reports destination-match packets dropped.
// RULE11: Priority used only if static and global enable.
// RULE12: Upper read-back reports port and last MAC bits.
// RULE13: First-entry restarts walk from table start.
// RULE14: Software clears walk command bit before next.
// RULE15: Read-back held stable between walk commands.
module mte_entry_regs #(
   parameter int MAC_W = 48
) (
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic                   ce,
   input  wire logic [`MTE_ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]            reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [31:0]            reg_rdata,
   input  wire logic                   cmd_first,
   input  wire logic                   cmd_next,
   input  wire logic                   dest_addr_priority_first,
   input  wire logic                   walk_done,
   input  wire logic                   walk_found,
   input  wire logic                   walk_end,
   input  wire logic [MAC_W-1:0]       walk_mac,
   input  wire mte_pkg::mte_port_t     walk_port,
   input  wire logic                   walk_static,
   input  wire logic                   walk_filter,
   input  wire mte_pkg::mte_prio_t     walk_prio,
   output logic                        walk_start,
   output logic                        walk_restart,
   output logic                        walk_busy,
   output logic      [31:0]            table_write_high,
   output logic      [2:0]             staged_port_mask,
   output logic      [15:0]            staged_mac_last,
   output logic                        readback_prio_active
);

   if (MAC_W != 48) begin : g_mac_w_check
      $error("mte_entry_regs supports only 48-bit MAC addresses");
   end

   mte_pkg::mte_state_t state_reg;
   mte_pkg::mte_state_t state_next;
   logic [31:0]         rb_low_reg;
   logic [31:0]         rb_high_reg;
   logic [31:0]         wr_high_reg;
   logic [31:0]         rdata_next;
   logic [2:0]          mask_next;

   wire sel_wr_high = (reg_addr == `MTE_OFF_WR_HIGH);
   wire sel_rb_low  = (reg_addr == `MTE_OFF_RB_LOW);
   wire sel_rb_high = (reg_addr == `MTE_OFF_RB_HIGH);
   wire walk_cmd    = cmd_first | cmd_next;
   // A result sharing an edge with a new command wins; the engine is still busy then.
   wire load_rb     = (state_reg == mte_pkg::MTE_SEARCH) & walk_done;
   wire [31:0] wr_high_next = reg_wdata & `MTE_HIGH_MASK;

   // Upper read-back word: flags, priority, port and last 16 MAC bits.
   wire [31:0] rb_high_next = {`MTE_RSVD_ZERO, walk_found, walk_end, walk_static, walk_filter, walk_prio,
                               walk_port, walk_mac[MAC_W-1:`MTE_HIGH_MAC_LO]}; // RULE12 RULE8 RULE9 RULE10

   wire [2:0] staged_code = wr_high_reg[`MTE_PORT_HI:`MTE_PORT_LO];

   // Port code to port mask, one bit per switch port.
   always_comb begin
      case (staged_code)
         3'h0:    mask_next = `MTE_MASK_P0;   // RULE1
         3'h1:    mask_next = `MTE_MASK_P1;   // RULE1
         3'h2:    mask_next = `MTE_MASK_P2;   // RULE1
         3'h3:    mask_next = `MTE_MASK_NONE; // RULE1
         3'h4:    mask_next = `MTE_MASK_P01;  // RULE2
         3'h5:    mask_next = `MTE_MASK_P02;  // RULE2
         3'h6:    mask_next = `MTE_MASK_P12;  // RULE2
         default: mask_next = `MTE_MASK_ALL;  // RULE2
      endcase
   end

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         mte_pkg::MTE_IDLE: begin
            if (walk_cmd) begin
               state_next = mte_pkg::MTE_SEARCH;
            end
         end
         mte_pkg::MTE_SEARCH: begin
            if (walk_done) begin
               state_next = mte_pkg::MTE_IDLE;
            end
         end
         default: state_next = mte_pkg::MTE_IDLE;
      endcase
   end

   always_comb begin
      if (sel_rb_low) begin
         rdata_next = rb_low_reg;
      end else if (sel_rb_high) begin
         rdata_next = rb_high_reg;
      end else if (sel_wr_high) begin
         rdata_next = wr_high_reg;
      end else begin
         rdata_next = `MTE_RST_WORD;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= mte_pkg::MTE_IDLE;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   // Staged upper entry word; reserved bits are stored as zero.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_high_reg <= `MTE_RST_WORD;
      end else if (ce && reg_wr && sel_wr_high) begin
         wr_high_reg <= wr_high_next; // RULE3
      end
   end

   // Read-back words change only on a walk command or its result.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rb_low_reg  <= `MTE_RST_WORD;
         rb_high_reg <= `MTE_RST_WORD;
      end else if (ce) begin
         if (load_rb) begin
            rb_low_reg  <= walk_mac[`MTE_LOW_HI:`MTE_LOW_LO]; // RULE4 RULE5
            rb_high_reg <= rb_high_next;   // RULE5 RULE7
         end else if (walk_cmd && state_reg == mte_pkg::MTE_IDLE) begin
            rb_high_reg[`MTE_BIT_VALID] <= 1'b0; // RULE7
            rb_high_reg[`MTE_BIT_END]   <= 1'b0; // RULE15
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= `MTE_RST_WORD;
      end else if (ce && reg_rd) begin
         reg_rdata <= rdata_next;
      end
   end

   // Start pulse toward the table engine; first-entry also rewinds its pointer.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         walk_start   <= 1'b0;
         walk_restart <= 1'b0;
         walk_busy    <= 1'b0;
      end else if (ce) begin
         walk_start   <= walk_cmd & (state_reg == mte_pkg::MTE_IDLE);
         walk_restart <= cmd_first & (state_reg == mte_pkg::MTE_IDLE); // RULE13
         walk_busy    <= (state_next == mte_pkg::MTE_SEARCH);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         table_write_high     <= `MTE_RST_WORD;
         staged_port_mask     <= `MTE_MASK_NONE;
         staged_mac_last      <= `MTE_HALF_ZERO;
         readback_prio_active <= 1'b0;
      end else if (ce) begin
         table_write_high     <= wr_high_reg;
         staged_port_mask     <= mask_next;                                // RULE1 RULE2
         staged_mac_last      <= wr_high_reg[`MTE_MAC_HI:`MTE_MAC_LO];    // RULE3
         readback_prio_active <= rb_high_reg[`MTE_BIT_STATIC] & dest_addr_priority_first; // RULE11
      end
   end

   // Checks on the logic above.

   valid_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
      ce && walk_cmd && state_reg == mte_pkg::MTE_IDLE |=> !rb_high_reg[`MTE_BIT_VALID])
      else $error("valid flag not cleared by walk command");

   valid_set_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
      ce && load_rb |=> rb_high_reg[`MTE_BIT_VALID] == $past(walk_found))
      else $error("valid flag does not follow search result");

   end_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
      ce && load_rb && walk_end |=> rb_high_reg[`MTE_BIT_END])
      else $error("end-of-table flag missing");

   low_load_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
      !(ce && load_rb) |=> $stable(rb_low_reg))
      else $error("lower read-back changed without walk result");

   low_mac_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
      ce && load_rb |=> rb_low_reg == $past(walk_mac[`MTE_LOW_HI:`MTE_LOW_LO]))
      else $error("lower read-back not first 32 MAC bits");

   high_stable_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
      !(ce && (walk_cmd || walk_done)) |=> $stable(rb_high_reg))
      else $error("upper read-back changed between walks");

   high_fields_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
      ce && load_rb |=> rb_high_reg[`MTE_PORT_HI:`MTE_PORT_LO] == $past(walk_port)
         && rb_high_reg[`MTE_MAC_HI:`MTE_MAC_LO] == $past(walk_mac[MAC_W-1:`MTE_HIGH_MAC_LO]))
      else $error("upper read-back port or MAC wrong");

   single_port_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
      ce && !wr_high_reg[`MTE_BIT_MULTI] |=> $countones(staged_port_mask) <= 1)
      else $error("single-port code gave several ports");

   multi_port_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
      ce && wr_high_reg[`MTE_BIT_MULTI] |=> $countones(staged_port_mask) >= 2)
      else $error("multi-port code gave fewer than two ports");

   restart_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
      ce && cmd_first && state_reg == mte_pkg::MTE_IDLE |=> walk_restart && walk_start)
      else $error("first-entry did not restart the walk");

   prio_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
      ce && !dest_addr_priority_first |=> !readback_prio_active)
      else $error("priority active without global enable");

   end_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
      ce && walk_cmd && state_reg == mte_pkg::MTE_IDLE |=> !rb_high_reg[`MTE_BIT_END])
      else $error("end-of-table flag not cleared by walk command");

   end_absent_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
      ce && load_rb && !walk_end |=> !rb_high_reg[`MTE_BIT_END])
      else $error("end-of-table flag set without table end");

   static_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
      ce && load_rb |=> rb_high_reg[`MTE_BIT_STATIC] == $past(walk_static))
      else $error("static flag does not follow entry");

   filter_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
      ce && load_rb |=> rb_high_reg[`MTE_BIT_FILTER] == $past(walk_filter))
      else $error("filter flag does not follow entry");

   prio_field_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
      ce && load_rb |=> rb_high_reg[`MTE_PRIO_HI:`MTE_PRIO_LO] == $past(walk_prio))
      else $error("priority field does not follow entry");

   prio_static_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
      ce && !rb_high_reg[`MTE_BIT_STATIC] |=> !readback_prio_active)
      else $error("priority active for non-static entry");

   prio_on_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
      ce && rb_high_reg[`MTE_BIT_STATIC] && dest_addr_priority_first |=> readback_prio_active)
      else $error("priority inactive for static entry with global enable");

   rsvd_zero_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
      rb_high_reg[`MTE_RSVD_HI:`MTE_RSVD_LO] == `MTE_RSVD_ZERO)
      else $error("reserved read-back bits not zero");

   reserved_code_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
      ce && staged_code == `MTE_CODE_RSVD |=> staged_port_mask == `MTE_MASK_NONE)
      else $error("reserved port code selected a port");

   staged_mac_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
      ce |=> staged_mac_last == $past(wr_high_reg[`MTE_MAC_HI:`MTE_MAC_LO]))
      else $error("staged MAC bits do not follow staged word");

   wr_refused_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
      !(ce && reg_wr && sel_wr_high) |=> $stable(wr_high_reg))
      else $error("staged word changed without a write to it");

   start_pulse_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
      ce && walk_start |=> !walk_start)
      else $error("walk start longer than one cycle");

   busy_refuse_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
      ce && state_reg == mte_pkg::MTE_SEARCH |=> !walk_start)
      else $error("walk started while search busy");

   restart_only_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
      ce && !cmd_first |=> !walk_restart)
      else $error("walk restart without first-entry command");

   busy_state_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
      walk_busy == (state_reg == mte_pkg::MTE_SEARCH))
      else $error("busy output disagrees with walk state");

   rd_low_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
      ce && reg_rd && sel_rb_low |=> reg_rdata == $past(rb_low_reg))
      else $error("read of lower read-back word wrong");

   rd_high_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
      ce && reg_rd && sel_rb_high |=> reg_rdata == $past(rb_high_reg))
      else $error("read of upper read-back word wrong");

   freeze_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
      !ce |=> $stable(state_reg) && $stable(rb_high_reg) && $stable(reg_rdata))
      else $error("state changed while clock enable low");

endmodule

/* pkg/mte_params.svh */
`ifndef MTE_PARAMS_SVH
`define MTE_PARAMS_SVH

`define MTE_ADDR_W        16
`define MTE_OFF_WR_HIGH   16'h1802
`define MTE_OFF_RB_LOW    16'h1805
`define MTE_OFF_RB_HIGH   16'h1806
`define MTE_RST_WORD      32'h00000000
`define MTE_HIGH_MASK     32'h01FFFFFF
`define MTE_BIT_VALID     24
`define MTE_BIT_END       23
`define MTE_BIT_STATIC    22
`define MTE_BIT_FILTER    21
`define MTE_PRIO_HI       20
`define MTE_PRIO_LO       19
`define MTE_PORT_HI       18
`define MTE_PORT_LO       16
`define MTE_BIT_MULTI     18
`define MTE_MAC_HI        15
`define MTE_MAC_LO        0
`define MTE_LOW_HI        31
`define MTE_LOW_LO        0
`define MTE_HIGH_MAC_LO   32
`define MTE_RSVD_HI       31
`define MTE_RSVD_LO       25
`define MTE_RSVD_ZERO     7'h00
`define MTE_HALF_ZERO     16'h0000
`define MTE_CODE_RSVD     3'h3
`define MTE_MASK_NONE     3'h0
`define MTE_MASK_P0       3'h1
`define MTE_MASK_P1       3'h2
`define MTE_MASK_P2       3'h4
`define MTE_MASK_P01      3'h3
`define MTE_MASK_P02      3'h5
`define MTE_MASK_P12      3'h6
`define MTE_MASK_ALL      3'h7

`endif

/* pkg/mte_pkg.sv */
package mte_pkg;

   // Gray-coded walk states: idle and waiting for the table engine.
   typedef enum logic [0:0] {
      MTE_IDLE   = 1'b0,
      MTE_SEARCH = 1'b1
   } mte_state_t;

   typedef logic [2:0] mte_port_t;
   typedef logic [1:0] mte_prio_t;

endpackage

/* bench/mte_entry_regs_tb.sv */
`timescale 1ns/1ns
`include "mte_params.svh"

module mte_entry_regs_tb;
   logic                 clk;
   logic                 rst_n;
   logic                 ce;
   logic [15:0]          reg_addr;
   logic [31:0]          reg_wdata;
   logic                 reg_wr;
   logic                 reg_rd;
   logic [31:0]          reg_rdata;
   logic                 cmd_first;
   logic                 cmd_next;
   logic                 dapf;
   logic                 walk_done;
   logic                 walk_found;
   logic                 walk_end;
   logic [47:0]          walk_mac;
   mte_pkg::mte_port_t   walk_port;
   logic                 walk_static;
   logic                 walk_filter;
   mte_pkg::mte_prio_t   walk_prio;
   logic                 walk_start;
   logic                 walk_restart;
   logic                 walk_busy;
   logic [31:0]          table_write_high;
   logic [2:0]           staged_port_mask;
   logic [15:0]          staged_mac_last;
   logic                 readback_prio_active;
   int                   err_count = 0;
   int                   n_tests = 0;
   int                   cycles = 0;
   int                   n_start = 0;
   int                   n_restart = 0;
   // Rows: staged write words with reserved bits set, and the port mask each should give.
   localparam logic [31:0] ROW_WD [8] = '{32'hFE00_1234, 32'hFF01_8001, 32'hFE02_00FF, 32'hFF03_7FFE,
                                          32'hFE04_ABCD, 32'hFF05_0001, 32'hFE06_FFFF, 32'hFF07_5A5A};
   localparam logic [2:0]  ROW_MK [8] = '{3'h1, 3'h2, 3'h4, 3'h0, 3'h3, 3'h5, 3'h6, 3'h7};

   mte_entry_regs #(.MAC_W(48)) mte_entry_regs_inst (
      .clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_first(cmd_first),
      .cmd_next(cmd_next), .dest_addr_priority_first(dapf), .walk_done(walk_done),
      .walk_found(walk_found), .walk_end(walk_end), .walk_mac(walk_mac), .walk_port(walk_port),
      .walk_static(walk_static), .walk_filter(walk_filter), .walk_prio(walk_prio),
      .walk_start(walk_start), .walk_restart(walk_restart), .walk_busy(walk_busy),
      .table_write_high(table_write_high), .staged_port_mask(staged_port_mask),
      .staged_mac_last(staged_mac_last), .readback_prio_active(readback_prio_active));

   always #20 clk = ~clk;

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (walk_start === 1'b1) n_start <= n_start + 1;
      if (walk_restart === 1'b1) n_restart <= n_restart + 1;
      if (cycles > 3000) begin
         err_count = err_count + 1;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         err_count = err_count + 1;
         $display("[ERR] t=%0t got %08h exp %08h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
      tick(1);
      reg_wr = 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, input logic [31:0] exp);
      reg_addr = a; reg_rd = 1'b1;
      tick(1);
      reg_rd = 1'b0;
      tick(1);
      chk(reg_rdata, exp);
   endtask

   task automatic result(input logic f, input logic e, input logic [47:0] m, input logic [2:0] p,
                         input logic s, input logic fl, input logic [1:0] pr);
      walk_found = f; walk_end = e; walk_mac = m; walk_port = p;
      walk_static = s; walk_filter = fl; walk_prio = pr; walk_done = 1'b1;
      tick(1);
      walk_done = 1'b0;
      tick(1);
   endtask

   initial begin
      clk = 0; rst_n = 0; ce = 1; reg_addr = 0; reg_wdata = 0; reg_wr = 0; reg_rd = 0;
      cmd_first = 0; cmd_next = 0; dapf = 0; walk_done = 0; walk_found = 0; walk_end = 0;
      walk_mac = 0; walk_port = 0; walk_static = 0; walk_filter = 0; walk_prio = 0;
      repeat (5) @(posedge clk);
      #1 rst_n = 1;
      rd(`MTE_OFF_RB_LOW, 32'h0000_0000);
      rd(`MTE_OFF_RB_HIGH, 32'h0000_0000);
      $display("test reset values done");
      for (int i = 0; i < 8; i++) begin
         wr(`MTE_OFF_WR_HIGH, ROW_WD[i]);
         tick(2);
         chk({29'h0, staged_port_mask}, {29'h0, ROW_MK[i]});
         chk({16'h0, staged_mac_last}, {16'h0, ROW_WD[i][15:0]});
         chk(table_write_high, ROW_WD[i] & 32'h01FF_FFFF);
      end
      rd(16'h1234, 32'h0000_0000);
      $display("test staged word rows done");
      cmd_first = 1'b1;
      tick(1);
      cmd_first = 1'b0;
      tick(2);
      chk({31'h0, walk_busy}, 32'h1);
      chk(n_start, 1);
      chk(n_restart, 1);
      result(1'b1, 1'b0, 48'hA5B6_1234_5679, 3'h5, 1'b1, 1'b1, 2'h2);
      chk({31'h0, walk_busy}, 32'h0);
      rd(`MTE_OFF_RB_LOW, 32'h1234_5679);
      rd(`MTE_OFF_RB_HIGH, 32'h0175_A5B6);
      chk({31'h0, readback_prio_active}, 32'h0);
      dapf = 1'b1;
      tick(2);
      chk({31'h0, readback_prio_active}, 32'h1);
      $display("test first entry done");
      wr(`MTE_OFF_RB_LOW, 32'hFFFF_FFFF);
      wr(`MTE_OFF_RB_HIGH, 32'hFFFF_FFFF);
      result(1'b1, 1'b1, 48'hFFFF_FFFF_FFFF, 3'h7, 1'b0, 1'b0, 2'h3);
      rd(`MTE_OFF_RB_LOW, 32'h1234_5679);
      rd(`MTE_OFF_RB_HIGH, 32'h0175_A5B6);
      $display("test readback hold done");
      cmd_next = 1'b1;
      tick(1);
      cmd_next = 1'b0;
      tick(1);
      cmd_first = 1'b1;
      tick(1);
      cmd_first = 1'b0;
      rd(`MTE_OFF_RB_HIGH, 32'h0075_A5B6);
      chk(n_start, 2);
      chk(n_restart, 1);
      result(1'b1, 1'b1, 48'h0F0E_0D0C_0B0A, 3'h2, 1'b0, 1'b0, 2'h1);
      rd(`MTE_OFF_RB_LOW, 32'h0D0C_0B0A);
      rd(`MTE_OFF_RB_HIGH, 32'h018A_0F0E);
      chk({31'h0, readback_prio_active}, 32'h0);
      $display("test next entry to end done");
      cmd_next = 1'b1;
      tick(1);
      cmd_next = 1'b0;
      tick(1);
      walk_found = 1'b0;
      walk_end = 1'b1;
      walk_mac = 48'h1111_2222_3333;
      walk_port = 3'h0;
      walk_static = 1'b0;
      walk_filter = 1'b0;
      walk_prio = 2'h0;
      walk_done = 1'b1;
      cmd_first = 1'b1;
      tick(1);
      walk_done = 1'b0;
      cmd_first = 1'b0;
      tick(1);
      rd(`MTE_OFF_RB_HIGH, 32'h0080_1111);
      rd(`MTE_OFF_RB_LOW, 32'h2222_3333);
      chk(n_start, 3);
      chk(n_restart, 1);
      $display("test end without entry done");
      ce = 1'b0;
      cmd_next = 1'b1;
      reg_addr = `MTE_OFF_RB_HIGH;
      reg_rd = 1'b1;
      tick(2);
      ce = 1'b1;
      cmd_next = 1'b0;
      reg_rd = 1'b0;
      tick(1);
      chk(reg_rdata, 32'h2222_3333);
      chk(n_start, 3);
      chk({31'h0, walk_busy}, 32'h0);
      $display("test clock enable freeze done");
      rst_n = 1'b0;
      tick(1);
      chk(reg_rdata, 32'h0000_0000);
      chk(table_write_high, 32'h0000_0000);
      chk({29'h0, staged_port_mask}, 32'h0);
      chk({16'h0, staged_mac_last}, 32'h0);
      rst_n = 1'b1;
      tick(2);
      chk({29'h0, staged_port_mask}, 32'h1);
      rd(`MTE_OFF_RB_HIGH, 32'h0000_0000);
      rd(`MTE_OFF_RB_LOW, 32'h0000_0000);
      $display("test mid-run reset done");
      end_sim();
   end
endmodule
